// File: pkg/burst_sram_map.vh
// Purpose: constants of the pipelined burst sram port
// Assumes: included by bare name before the module that uses it
// Notes:   the array is a small flip-flop model of the storage core
`ifndef BURST_SRAM_MAP_VH
`define BURST_SRAM_MAP_VH

// geometry of the storage core and of the data port
`define SRAM_ADDR_W         8
`define SRAM_DEPTH          256
`define SRAM_LANES          4
`define SRAM_LANE_W         8
`define SRAM_WORD_LANE_W    9
`define SRAM_DATA_W         32
`define SRAM_WORD_W         36

// burst counter: two low address bits, wraps within four
`define BURST_BITS          2
`define BURST_STEP_RESET    2'h0
`define BURST_STEP_ONE      2'h1
`define BURST_ORDER_LINEAR  1'b0

// sleep entry and exit, each two clock cycles
`define SLEEP_ENTRY_CYC     2'h2
`define SLEEP_EXIT_CYC      2'h2
`define SLEEP_CNT_ONE       2'h1
`define SLEEP_CNT_RESET     2'h0

// reset values of the pipeline
`define ADDR_RESET          8'h00
`define DATA_RESET          32'h0000_0000
`define PARITY_RESET        4'h0
`define MASK_RESET          4'hF

`endif

// File: rtl/burst_sram_port.v
// Purpose: synchronous port of a pipelined burst sram with no turnaround
// Assumes: all inputs but arst_n_i synchronous to clk_i; out_drive_n_i and sleep_request_i gate the drivers without clock
// Notes:   storage is a small flip-flop array behind the pipeline
`include "burst_sram_map.vh"

module burst_sram_port (
    input  wire                        clk_i,
    input  wire                        arst_n_i,
    input  wire                        clk_en_i,
    input  wire                        cycle_qualify_n_i,
    input  wire                        chip_select_one_n_i,
    input  wire                        chip_select_two_i,
    input  wire                        chip_select_three_n_i,
    input  wire                        advance_or_load_i,
    input  wire                        write_select_n_i,
    input  wire [`SRAM_LANES-1:0]      byte_lane_mask_n_i,
    input  wire                        out_drive_n_i,
    input  wire                        burst_order_i,
    input  wire                        sleep_request_i,
    input  wire [`SRAM_ADDR_W-1:0]     addr_i,
    input  wire [`SRAM_DATA_W-1:0]     data_i,
    output wire [`SRAM_DATA_W-1:0]     data_o,
    output wire                        data_oe_n_o,
    input  wire [`SRAM_LANES-1:0]      parity_lines_i,
    output wire [`SRAM_LANES-1:0]      parity_lines_o,
    output wire                        parity_lines_oe_n_o,
    output wire                        asleep_o
);

    // sleep state codes
    localparam [1:0] SLP_AWAKE  = 2'h0;
    localparam [1:0] SLP_ENTER  = 2'h1;
    localparam [1:0] SLP_ASLEEP = 2'h2;
    localparam [1:0] SLP_EXIT   = 2'h3;

    // storage core
    reg  [`SRAM_WORD_W-1:0]   mem [0:`SRAM_DEPTH-1];

    // burst state
    reg  [`SRAM_ADDR_W-1:0]   base_q;
    reg  [`SRAM_ADDR_W-1:0]   base_d;
    reg  [`BURST_BITS-1:0]    step_q;
    reg  [`BURST_BITS-1:0]    step_d;
    reg                       burst_act_q;
    reg                       burst_act_d;
    reg                       burst_write_q;
    reg                       burst_write_d;

    // stage one: operation taken at the issuing edge
    reg                       s1_valid_q;
    reg                       s1_valid_d;
    reg                       s1_write_q;
    reg                       s1_write_d;
    reg  [`SRAM_ADDR_W-1:0]   s1_addr_q;
    reg  [`SRAM_ADDR_W-1:0]   s1_addr_d;
    reg  [`SRAM_LANES-1:0]    s1_mask_q;
    reg  [`SRAM_LANES-1:0]    s1_mask_d;

    // stage two: write waiting for its data beat
    reg                       s2_valid_q;
    reg  [`SRAM_ADDR_W-1:0]   s2_addr_q;
    reg  [`SRAM_LANES-1:0]    s2_mask_q;

    // output register
    reg                       rd_drive_q;
    reg  [`SRAM_DATA_W-1:0]   dout_q;
    reg  [`SRAM_LANES-1:0]    pout_q;
    reg  [`SRAM_DATA_W-1:0]   rd_data;
    reg  [`SRAM_LANES-1:0]    rd_par;

    // sleep control
    reg  [1:0]                slp_state_q;
    reg  [1:0]                slp_state_d;
    reg  [1:0]                slp_cnt_q;
    reg  [1:0]                slp_cnt_d;
    reg                       asleep_q;

    wire                      selected;
    wire                      awake;
    wire                      step_edge;
    wire [`BURST_BITS-1:0]    next_step;
    reg  [`BURST_BITS-1:0]    burst_low;
    wire                      drive_en;
    integer                   k;
    integer                   lane;

    // ------------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------------

    assign selected = ~chip_select_one_n_i & chip_select_two_i &
                      ~chip_select_three_n_i;

    assign awake = (slp_state_q == SLP_AWAKE);

    // while awake, a suspended edge leaves every pipeline and burst flop alone
    assign step_edge = clk_en_i & ~cycle_qualify_n_i & awake;

    assign next_step = step_q + `BURST_STEP_ONE;

    always @* begin
        if (burst_order_i == `BURST_ORDER_LINEAR) begin
            burst_low = base_q[`BURST_BITS-1:0] + next_step;
        end else begin
            burst_low = base_q[`BURST_BITS-1:0] ^ next_step;
        end
    end

    always @* begin
        base_d        = base_q;
        step_d        = step_q;
        burst_act_d   = burst_act_q;
        burst_write_d = burst_write_q;
        s1_valid_d    = 1'b0;
        s1_write_d    = 1'b0;
        s1_addr_d     = s1_addr_q;
        s1_mask_d     = byte_lane_mask_n_i;
        if (advance_or_load_i) begin
            // selects and write select are not looked at here
            if (burst_act_q) begin
                step_d     = next_step;
                s1_valid_d = 1'b1;
                s1_write_d = burst_write_q;
                s1_addr_d  = {base_q[`SRAM_ADDR_W-1:`BURST_BITS],
                              burst_low};
            end
            // a continue after a deselect stays deselected
        end else if (selected) begin
            base_d        = addr_i;
            step_d        = `BURST_STEP_RESET;
            burst_act_d   = 1'b1;
            burst_write_d = ~write_select_n_i;
            s1_valid_d    = 1'b1;
            s1_write_d    = ~write_select_n_i;
            s1_addr_d     = addr_i;
        end else begin
            burst_act_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // issue stage and burst counter
    // ------------------------------------------------------------------

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            base_q        <= `ADDR_RESET;
            step_q        <= `BURST_STEP_RESET;
            burst_act_q   <= 1'b0;
            burst_write_q <= 1'b0;
            s1_valid_q    <= 1'b0;
            s1_write_q    <= 1'b0;
            s1_addr_q     <= `ADDR_RESET;
            s1_mask_q     <= `MASK_RESET;
        end else if (clk_en_i && !awake) begin
            // pending work is dropped on the way into sleep
            burst_act_q <= 1'b0;
            s1_valid_q  <= 1'b0;
        end else if (step_edge) begin
            base_q        <= base_d;
            step_q        <= step_d;
            burst_act_q   <= burst_act_d;
            burst_write_q <= burst_write_d;
            s1_valid_q    <= s1_valid_d;
            s1_write_q    <= s1_write_d;
            s1_addr_q     <= s1_addr_d;
            s1_mask_q     <= s1_mask_d;
        end
    end

    // ------------------------------------------------------------------
    // output register and write data stage
    // ------------------------------------------------------------------

    always @* begin
        rd_data = `DATA_RESET;
        rd_par  = `PARITY_RESET;
        for (k = 0; k < `SRAM_LANES; k = k + 1) begin
            rd_data[k*`SRAM_LANE_W +: `SRAM_LANE_W] =
                mem[s1_addr_q][k*`SRAM_WORD_LANE_W +: `SRAM_LANE_W];
            rd_par[k] =
                mem[s1_addr_q][k*`SRAM_WORD_LANE_W + `SRAM_LANE_W];
        end
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_drive_q <= 1'b0;
            dout_q     <= `DATA_RESET;
            pout_q     <= `PARITY_RESET;
            s2_valid_q <= 1'b0;
            s2_addr_q  <= `ADDR_RESET;
            s2_mask_q  <= `MASK_RESET;
        end else if (clk_en_i && !awake) begin
            rd_drive_q <= 1'b0;
            s2_valid_q <= 1'b0;
        end else if (step_edge) begin
            // a write or deselect in stage one turns the drivers off
            rd_drive_q <= s1_valid_q & ~s1_write_q;
            if (s1_valid_q && !s1_write_q) begin
                dout_q <= rd_data;
                pout_q <= rd_par;
            end
            s2_valid_q <= s1_valid_q & s1_write_q;
            s2_addr_q  <= s1_addr_q;
            s2_mask_q  <= s1_mask_q;
        end
    end

    // storage core carries no reset: contents survive reset and sleep
    always @(posedge clk_i) begin
        if (step_edge && s2_valid_q) begin
            for (lane = 0; lane < `SRAM_LANES; lane = lane + 1) begin
                if (!s2_mask_q[lane]) begin
                    mem[s2_addr_q][lane*`SRAM_WORD_LANE_W +: `SRAM_LANE_W]
                        <= data_i[lane*`SRAM_LANE_W +: `SRAM_LANE_W];
                    mem[s2_addr_q][lane*`SRAM_WORD_LANE_W + `SRAM_LANE_W]
                        <= parity_lines_i[lane];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // sleep entry and exit
    // ------------------------------------------------------------------

    always @* begin
        slp_state_d = slp_state_q;
        slp_cnt_d   = slp_cnt_q;
        case (slp_state_q)
            SLP_AWAKE: begin
                if (sleep_request_i) begin
                    slp_state_d = SLP_ENTER;
                    slp_cnt_d   = `SLEEP_CNT_ONE;
                end
            end
            SLP_ENTER: begin
                if (slp_cnt_q >= `SLEEP_ENTRY_CYC - `SLEEP_CNT_ONE) begin
                    slp_state_d = SLP_ASLEEP;
                    slp_cnt_d   = `SLEEP_CNT_RESET;
                end else begin
                    slp_cnt_d = slp_cnt_q + `SLEEP_CNT_ONE;
                end
            end
            SLP_ASLEEP: begin
                if (!sleep_request_i) begin
                    slp_state_d = SLP_EXIT;
                    slp_cnt_d   = `SLEEP_CNT_ONE;
                end
            end
            SLP_EXIT: begin
                if (sleep_request_i) begin
                    slp_state_d = SLP_ENTER;
                    slp_cnt_d   = `SLEEP_CNT_ONE;
                end else if (slp_cnt_q >=
                             `SLEEP_EXIT_CYC - `SLEEP_CNT_ONE) begin
                    // selects are ignored until this point
                    slp_state_d = SLP_AWAKE;
                    slp_cnt_d   = `SLEEP_CNT_RESET;
                end else begin
                    slp_cnt_d = slp_cnt_q + `SLEEP_CNT_ONE;
                end
            end
            default: begin
                slp_state_d = SLP_AWAKE;
                slp_cnt_d   = `SLEEP_CNT_RESET;
            end
        endcase
    end

    // sleep does not wait for the qualify input, only for clk_en_i
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            slp_state_q <= SLP_AWAKE;
            slp_cnt_q   <= `SLEEP_CNT_RESET;
            asleep_q    <= 1'b0;
        end else if (clk_en_i) begin
            slp_state_q <= slp_state_d;
            slp_cnt_q   <= slp_cnt_d;
            asleep_q    <= (slp_state_d == SLP_ASLEEP);
        end
    end

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------

    // output drive acts without the clock; a pending sleep request
    // releases the lines at once so the bus is never left contested
    assign drive_en = rd_drive_q & ~out_drive_n_i & awake &
                      ~sleep_request_i;

    assign data_oe_n_o         = ~drive_en;
    assign parity_lines_oe_n_o = ~drive_en;
    assign data_o              = dout_q;
    assign parity_lines_o      = pout_q;
    assign asleep_o            = asleep_q;

endmodule

// File: verification/sram_port_checker.sv
// Purpose: port assertions of the burst sram port
// Assumes: bound to burst_sram_port; clk_en_i low counts as a stall
// Notes:   states during an exit from sleep are not seen at the ports
module sram_port_checker (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        clk_en_i,
    input wire logic        cycle_qualify_n_i,
    input wire logic        chip_select_one_n_i,
    input wire logic        chip_select_two_i,
    input wire logic        chip_select_three_n_i,
    input wire logic        advance_or_load_i,
    input wire logic        write_select_n_i,
    input wire logic        out_drive_n_i,
    input wire logic        sleep_request_i,
    input wire logic [31:0] data_o,
    input wire logic        data_oe_n_o,
    input wire logic        asleep_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire q = clk_en_i && !cycle_qualify_n_i && !sleep_request_i && !asleep_o;
    wire ld = q && !advance_or_load_i;
    wire sel = !chip_select_one_n_i && chip_select_two_i
               && !chip_select_three_n_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_pwrup; $rose(arst_n_i) |-> data_oe_n_o; endproperty
    a_pwrup: assert property (p_pwrup) else $error("driven after reset");
    property p_stall;
        (cycle_qualify_n_i || !clk_en_i) && !sleep_request_i
        |=> $stable(data_o);
    endproperty
    a_stall: assert property (p_stall) else $error("stall moved data");
    property p_odrv; out_drive_n_i |-> data_oe_n_o; endproperty
    a_odrv: assert property (p_odrv) else $error("drives with od high");
    property p_slp; sleep_request_i |-> data_oe_n_o; endproperty
    a_slp: assert property (p_slp) else $error("drives in sleep");
    property p_wr; ld && sel && !write_select_n_i ##1 q |=> data_oe_n_o;
    endproperty
    a_wr: assert property (p_wr) else $error("drives after write");
    property p_desel; ld && !sel ##1 q |=> data_oe_n_o; endproperty
    a_desel: assert property (p_desel) else $error("deselect drives");
    property p_rd;
        ld && sel && write_select_n_i ##1 q && !out_drive_n_i
        |=> !data_oe_n_o || out_drive_n_i || sleep_request_i;
    endproperty
    a_rd: assert property (p_rd) else $error("read not driven");
    property p_cs2; ld && !chip_select_two_i ##1 q |=> data_oe_n_o;
    endproperty
    a_cs2: assert property (p_cs2) else $error("select two ignored");
    property p_nap;
        (sleep_request_i && clk_en_i) [*5] |-> asleep_o;
    endproperty
    a_nap: assert property (p_nap) else $error("sleep not entered");
endmodule
bind burst_sram_port sram_port_checker u_chk (
    .clk_i                 (clk_i),
    .arst_n_i              (arst_n_i),
    .clk_en_i              (clk_en_i),
    .cycle_qualify_n_i     (cycle_qualify_n_i),
    .chip_select_one_n_i   (chip_select_one_n_i),
    .chip_select_two_i     (chip_select_two_i),
    .chip_select_three_n_i (chip_select_three_n_i),
    .advance_or_load_i     (advance_or_load_i),
    .write_select_n_i      (write_select_n_i),
    .out_drive_n_i         (out_drive_n_i),
    .sleep_request_i       (sleep_request_i),
    .data_o                (data_o),
    .data_oe_n_o           (data_oe_n_o),
    .asleep_o              (asleep_o)
);

// File: verification/sram_bus_model.sv
// Purpose: controller side of the shared data and parity lines
// Assumes: the bench raises drv_en_i only in write data cycles
// Notes:   a floating line shows a pattern that changes every cycle
module sram_bus_model (
    input  wire logic        clk_i,
    input  wire logic        drv_en_i,
    input  wire logic [35:0] drv_val_i,
    input  wire logic [35:0] dev_val_i,
    input  wire logic        dev_oe_n_i,
    output logic      [35:0] line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] last_q = 36'h0;
    always_comb
        if (drv_en_i) line_o = drv_val_i;
        else if (!dev_oe_n_i) line_o = dev_val_i;
        else line_o = ~last_q;
    always @(posedge clk_i) last_q <= line_o;
endmodule

// File: verification/burst_sram_port_tb_top.sv
// Purpose: self-checking bench of the burst sram port
// Assumes: stalls come from cycle_qualify_n_i and from clk_en_i
// Notes:   inputs change 2 ns after each rising edge
module burst_sram_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, arst_n_i = 0, qn = 0, cs1n = 1, cs2 = 0, cs3n = 1;
    logic adv = 0, wsn = 1, oen = 0, mode = 0, slp = 0, den = 0, clk_en = 1;
    logic [3:0] mask = 4'hF, pout;
    logic [7:0] addr = 8'h00;
    logic [35:0] dval = 36'h0, line;
    logic [31:0] dout;
    logic doe, poe, asl;
    integer fail_count = 0, samples_checked = 0;
    burst_sram_port DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .clk_en_i(clk_en), .cycle_qualify_n_i(qn),
        .chip_select_one_n_i(cs1n), .chip_select_two_i(cs2),
        .chip_select_three_n_i(cs3n), .advance_or_load_i(adv),
        .write_select_n_i(wsn), .byte_lane_mask_n_i(mask),
        .out_drive_n_i(oen), .burst_order_i(mode),
        .sleep_request_i(slp), .addr_i(addr), .data_i(line[31:0]),
        .data_o(dout), .data_oe_n_o(doe), .parity_lines_i(line[35:32]),
        .parity_lines_o(pout), .parity_lines_oe_n_o(poe), .asleep_o(asl));
    sram_bus_model bus (.clk_i(clk_i), .drv_en_i(den), .drv_val_i(dval),
        .dev_val_i({pout, dout}), .dev_oe_n_i(doe), .line_o(line));
    task automatic chk(input logic [35:0] s, input logic [35:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cyc(input logic a, w, s, input logic [7:0] ad,
                       input logic [3:0] m, input logic d, input [35:0] v);
        adv = a;
        wsn = w;
        {cs1n, cs2, cs3n} = s ? 3'b010 : 3'b101;
        addr = ad;
        mask = m;
        den = d;
        dval = v;
        @(posedge clk_i);
        #2;
    endtask
    task automatic t_write;
        cyc(0, 0, 1, 8'h11, 4'h0, 0, 0);
        cyc(0, 0, 1, 8'h10, 4'h0, 0, 0);
        cyc(0, 0, 1, 8'h11, 4'hA, 1, 36'hF_1111_2222);
        chk(doe, 1'b1);
        cyc(0, 0, 1, 8'h10, 4'hF, 1, 36'hA_3333_4444);
        cyc(0, 1, 0, 8'h00, 4'hF, 1, 36'h0_5555_6666);
        cyc(0, 1, 1, 8'h11, 4'hF, 1, 36'h7_0BAD_F00D);
        cyc(0, 1, 1, 8'h10, 4'hF, 0, 0);
        chk({pout, dout}, 36'hA_1155_2266);
        cyc(0, 1, 0, 8'h00, 4'hF, 0, 0);
        chk({pout, dout}, 36'hA_3333_4444);
        chk({poe, doe}, 2'b00);
        cyc(0, 1, 0, 8'h00, 4'hF, 0, 0);
        chk({poe, doe}, 2'b11);
        // only select two inactive: must act as a deselect
        {cs1n, cs2, cs3n} = 3'b000;
        @(posedge clk_i);
        #2;
        cyc(0, 1, 0, 8'h00, 4'hF, 0, 0);
        chk({poe, doe}, 2'b11);
    endtask
    task automatic t_burst;
        mode = 0;
        for (int i = 0; i < 6; i++)
            cyc(i > 0 && i < 4, i > 0, i == 0, 8'h21, 4'h0, i > 1,
                {4'h3, 24'h0, 8'(i - 2)});
        mode = 1;
        for (int i = 0; i < 5; i++) begin
            cyc(i > 0 && i < 4, 1, i == 0, 8'h22, 4'hF, 0, 0);
            if (i > 0)
                chk({pout, dout},
                    {4'h3, 24'h0, 8'(((2 ^ (i - 1)) + 3) % 4)});
        end
    endtask
    task automatic t_stall;
        cyc(0, 1, 1, 8'h10, 4'hF, 0, 0);
        qn = 1;
        repeat (3) cyc(0, 0, 1, 8'h11, 4'h0, 0, 0);
        chk(doe, 1'b1);
        qn = 0;
        // clock enable low must freeze the pipeline the same way
        clk_en = 0;
        repeat (2) cyc(0, 0, 1, 8'h11, 4'h0, 0, 0);
        chk(doe, 1'b1);
        clk_en = 1;
        cyc(0, 1, 0, 8'h00, 4'hF, 0, 0);
        chk({pout, dout}, 36'hA_3333_4444);
        chk({poe, doe}, 2'b00);
        oen = 1;
        #1 chk(doe, 1'b1);
        @(posedge clk_i);
        #2 oen = 0;
    endtask
    task automatic t_sleep;
        cyc(0, 1, 0, 8'h00, 4'hF, 0, 0);
        slp = 1;
        repeat (6) cyc(0, 1, 0, 8'h00, 4'hF, 0, 0);
        chk({asl, doe}, 2'b11);
        slp = 0;
        repeat (4) cyc(0, 1, 0, 8'h00, 4'hF, 0, 0);
        chk(asl, 1'b0);
        cyc(0, 1, 1, 8'h11, 4'hF, 0, 0);
        cyc(0, 1, 0, 8'h00, 4'hF, 0, 0);
        chk({pout, dout}, 36'hA_1155_2266);
    endtask
    task automatic results;
        if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial forever #10 clk_i = ~clk_i;
    // run needs about 55 cycles, so 5 us only trips on a hang
    initial begin
        #5000;
        fail_count++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        #2 arst_n_i = 1;
        chk({poe, doe}, 2'b11);
        t_write();
        t_burst();
        t_stall();
        t_sleep();
        results();
    end
endmodule
